// File: mcseq_pkg.sv
// constants, state codes and result carrier for the measurement sequencer
// assumes a 100 MHz sequencer clock and 16-bit host registers
package mcseq_pkg;

  // host register offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CUR = 8'h01;
  localparam logic [7:0] REG_BUS = 8'h02;
  localparam logic [7:0] REG_PWR = 8'h03;
  localparam logic [7:0] REG_MASK = 8'h06;

  // configuration fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_AVG_LSB = 9;
  localparam int MASK_CONVERSION_READY_FLAG_BIT = 3;
  localparam logic [15:0] CFG_RESET = 16'h0007;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] RES_RESET = 16'h0000;

  // mode bits: bit0 current, bit1 bus voltage, bit2 continuous
  localparam int MODE_CUR_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_CONT_BIT = 2;

  // bus voltage saturates at the 40.96 V code
  localparam logic [15:0] BUS_FULL_SCALE = 16'h7FFF;

  // power = |I| * V * 1.5625 uW / 10 mW, done as multiply and shift
  localparam logic [15:0] PWR_RECIP = 16'h28F6;
  localparam int PWR_SHIFT = 26;
  localparam logic [15:0] PWR_MAX = 16'hFFFF;

  // recovery from power-down
  localparam int WAKE_TIME_US = 40;
  localparam int CLK_MHZ = 100;
  localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_SHUNT = 3'b010,
    ST_SWAIT = 3'b011,
    ST_BUS = 3'b100,
    ST_BWAIT = 3'b101
  } mcseq_state_t;

  typedef struct packed {
    logic [15:0] cur;
    logic [15:0] bus;
    logic [15:0] pwr;
  } mcseq_result_t;

endpackage

// File: mcseq_core.sv
// measurement conversion sequencer: shunt/bus ordering, averaging,
// current and power calculation, result registers and ready flag.
// assumes a register port fed by the serial bus front end and a
// converter that answers each start pulse with one valid data cycle.
//
// Functional notes
// [RULE1] continuous mode repeats shunt then bus conversion with no host help
// [RULE2] each shunt result gives a current, then power for that sample
// [RULE3] samples accumulate until the programmed averaging count is reached
// [RULE4] results load only when averaging completes and hold until next set
// [RULE5] host reads never disturb or restart a running sequence
// [RULE6] mode may convert only current or only bus voltage
// [RULE7] triggered mode writes start exactly one result set, then stop
// [RULE8] host must rewrite configuration for another single shot
// [RULE9] power-down halts conversions and switches input current off
// [RULE10] leaving power-down needs 40 us recovery before converting
// [RULE11] registers stay readable and writable during power-down
// [RULE12] power-down lasts until an active mode is written
// [RULE13] ready flag sets only after conversions, averaging and math finish
// [RULE14] configuration writes clear ready flag unless selecting power-down
// [RULE15] reading the mask/enable register clears the ready flag
// [RULE16] current and power math run alongside conversions, adding no time
// [RULE17] per-sample values live in an accumulator, not output registers
// [RULE18] bus voltage is 1.25 mV per code, full scale 40.96 V
// [RULE19] bus voltage accumulates too; all three results load together
// [RULE20] reverse current reads negative in two's complement
// [RULE21] power is always a non-negative magnitude
// [RULE22] continuous mode restarts at once with a cleared accumulator
// [RULE23] configuration write mid-sequence drops partial sums and restarts
`timescale 1ns/1ps

module mcseq_core #(
  parameter int ACC_W = 27
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_conv_valid,
  input wire logic [15:0] i_conv_data,
  output logic [15:0] o_reg_rdata,
  output logic o_conv_start,
  output logic o_conv_sel,
  output logic o_inputs_off,
  output logic o_conversion_ready_flag
);

  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction

  // magnitude first so reverse current still yields positive power
  function automatic logic [15:0] calc_power(input logic [15:0] cur,
                                             input logic [15:0] bus);
    logic [15:0] mag;
    logic [31:0] prod;
    logic [47:0] scaled;
    mag = cur[15] ? 16'(-cur) : cur;
    prod = mag * bus;
    scaled = (48'(prod) * 48'(mcseq_pkg::PWR_RECIP)) >> mcseq_pkg::PWR_SHIFT;
    calc_power = (scaled > 48'(mcseq_pkg::PWR_MAX)) ? mcseq_pkg::PWR_MAX
                                                    : scaled[15:0];
  endfunction

  localparam logic [12:0] WAKE_LOAD = 13'(mcseq_pkg::WAKE_CYCLES - 1);

  mcseq_pkg::mcseq_state_t state_reg, state_next;
  mcseq_pkg::mcseq_result_t res_reg;
  logic [15:0] cfg_reg;
  logic [15:0] mask_reg;
  logic [12:0] wake_cnt_reg;
  logic [10:0] sample_cnt_reg;
  logic [15:0] cur_hold_reg;
  logic [15:0] bus_hold_reg;
  logic signed [ACC_W-1:0] acc_cur_reg;
  logic [ACC_W-1:0] acc_bus_reg;
  logic [ACC_W-1:0] acc_pwr_reg;

  // decode
  wire cfg_wr = i_reg_wr && (i_reg_addr == mcseq_pkg::REG_CFG);
  wire mask_wr = i_reg_wr && (i_reg_addr == mcseq_pkg::REG_MASK);
  wire mask_rd = i_reg_rd && (i_reg_addr == mcseq_pkg::REG_MASK);
  wire [2:0] new_mode = i_reg_wdata[mcseq_pkg::CFG_MODE_LSB +: 3];
  wire new_pd = (new_mode[1:0] == 2'b00);
  wire [2:0] mode = cfg_reg[mcseq_pkg::CFG_MODE_LSB +: 3];
  wire mode_cont = mode[mcseq_pkg::MODE_CONT_BIT];
  wire [3:0] avg_sh = avg_shift(cfg_reg[mcseq_pkg::CFG_AVG_LSB +: 3]);
  wire [10:0] avg_last = 11'((12'h001 << avg_sh) - 12'h001);
  wire last_sample = (sample_cnt_reg == avg_last);
  wire mcseq_pkg::mcseq_state_t first_st =
    mode[mcseq_pkg::MODE_CUR_BIT] ? mcseq_pkg::ST_SHUNT
                                  : mcseq_pkg::ST_BUS; // RULE6
  wire mcseq_pkg::mcseq_state_t new_first_st =
    new_mode[mcseq_pkg::MODE_CUR_BIT] ? mcseq_pkg::ST_SHUNT
                                      : mcseq_pkg::ST_BUS;

  // sample capture; math is combinational on the capture cycle so it
  // costs no extra conversion time
  wire shunt_done = (state_reg == mcseq_pkg::ST_SWAIT) && i_conv_valid;
  wire bus_done = (state_reg == mcseq_pkg::ST_BWAIT) && i_conv_valid;
  wire [15:0] cur_s = shunt_done ? i_conv_data : cur_hold_reg; // RULE2 RULE20
  wire [15:0] bus_sat = i_conv_data[15] ? mcseq_pkg::BUS_FULL_SCALE
                                        : i_conv_data; // RULE18
  wire [15:0] bus_s = bus_done ? bus_sat : bus_hold_reg;
  wire sample_end = bus_done ||
    (shunt_done && !mode[mcseq_pkg::MODE_BUS_BIT]);
  wire [15:0] pwr_s = calc_power(cur_s, bus_s); // RULE2 RULE16 RULE21
  wire set_done = sample_end && last_sample;

  // accumulate all three values every sample
  wire signed [ACC_W-1:0] acc_cur_next = acc_cur_reg +
    {{(ACC_W-16){cur_s[15]}}, cur_s}; // RULE3 RULE17
  wire [ACC_W-1:0] acc_bus_next = acc_bus_reg +
    {{(ACC_W-16){1'b0}}, bus_s}; // RULE19
  wire [ACC_W-1:0] acc_pwr_next = acc_pwr_reg +
    {{(ACC_W-16){1'b0}}, pwr_s};
  wire signed [ACC_W-1:0] avg_cur = acc_cur_next >>> avg_sh;
  wire [ACC_W-1:0] avg_bus = acc_bus_next >> avg_sh;
  wire [ACC_W-1:0] avg_pwr = acc_pwr_next >> avg_sh;
  wire mcseq_pkg::mcseq_result_t res_new = '{
    cur: avg_cur[15:0], bus: avg_bus[15:0], pwr: avg_pwr[15:0]};

  // ready flag: set wins over either clear
  wire conversion_ready_flag_clr = (cfg_wr && !new_pd) || mask_rd; // RULE14 RULE15
  wire conversion_ready_flag_next = set_done || (o_conversion_ready_flag && !conversion_ready_flag_clr);

  // read mux; reads only select data, they never touch sequencing
  logic [15:0] rdata_next;
  always_comb begin
    case (i_reg_addr)
      mcseq_pkg::REG_CFG: rdata_next = cfg_reg;
      mcseq_pkg::REG_CUR: rdata_next = res_reg.cur;
      mcseq_pkg::REG_BUS: rdata_next = res_reg.bus;
      mcseq_pkg::REG_PWR: rdata_next = res_reg.pwr;
      mcseq_pkg::REG_MASK: begin
        rdata_next = mask_reg;
        rdata_next[mcseq_pkg::MASK_CONVERSION_READY_FLAG_BIT] = o_conversion_ready_flag;
      end
      default: rdata_next = 16'h0000;
    endcase
  end

  // sequencing; a config write overrides everything else
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mcseq_pkg::ST_IDLE: state_next = mcseq_pkg::ST_IDLE; // RULE12
      mcseq_pkg::ST_WAKE:
        if (wake_cnt_reg == 13'h0000) state_next = first_st; // RULE10
      mcseq_pkg::ST_SHUNT: state_next = mcseq_pkg::ST_SWAIT;
      mcseq_pkg::ST_BUS: state_next = mcseq_pkg::ST_BWAIT;
      mcseq_pkg::ST_SWAIT, mcseq_pkg::ST_BWAIT:
        if (shunt_done && mode[mcseq_pkg::MODE_BUS_BIT]) begin
          state_next = mcseq_pkg::ST_BUS; // RULE1
        end else if (sample_end) begin
          if (last_sample && !mode_cont) state_next = mcseq_pkg::ST_IDLE;
          else state_next = first_st; // RULE1 RULE3 RULE7 RULE22
        end
      default: state_next = mcseq_pkg::ST_IDLE;
    endcase
    if (cfg_wr) begin
      if (new_pd) state_next = mcseq_pkg::ST_IDLE; // RULE9
      // a rewrite during recovery must not cut the wait short
      else if (o_inputs_off || state_reg == mcseq_pkg::ST_WAKE)
        state_next = mcseq_pkg::ST_WAKE; // RULE10
      else state_next = new_first_st; // RULE7 RULE23
    end
  end

  wire start_next = (state_next == mcseq_pkg::ST_SHUNT) ||
    (state_next == mcseq_pkg::ST_BUS);
  wire acc_clear = cfg_wr || set_done; // RULE22 RULE23

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= mcseq_pkg::ST_WAKE;
      wake_cnt_reg <= WAKE_LOAD;
      o_inputs_off <= 1'b0;
      o_conv_start <= 1'b0;
      o_conv_sel <= 1'b0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      o_conv_start <= start_next;
      o_conv_sel <= (state_next == mcseq_pkg::ST_BUS);
      if (cfg_wr) o_inputs_off <= new_pd; // RULE9 RULE12
      if (cfg_wr && o_inputs_off) wake_cnt_reg <= WAKE_LOAD;
      else if (state_reg == mcseq_pkg::ST_WAKE &&
               wake_cnt_reg != 13'h0000)
        wake_cnt_reg <= wake_cnt_reg - 13'h0001; // RULE10
    end
  end

  // registers remain accessible in every mode
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg <= mcseq_pkg::CFG_RESET;
      mask_reg <= mcseq_pkg::MASK_RESET;
      o_reg_rdata <= 16'h0000;
      o_conversion_ready_flag <= 1'b0;
    end else if (i_clk_en) begin
      if (cfg_wr) cfg_reg <= i_reg_wdata; // RULE11
      if (mask_wr) mask_reg <= i_reg_wdata &
        ~(16'h0001 << mcseq_pkg::MASK_CONVERSION_READY_FLAG_BIT);
      if (i_reg_rd) o_reg_rdata <= rdata_next; // RULE5
      o_conversion_ready_flag <= conversion_ready_flag_next; // RULE13
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sample_cnt_reg <= 11'h000;
      cur_hold_reg <= 16'h0000;
      bus_hold_reg <= 16'h0000;
      acc_cur_reg <= '0;
      acc_bus_reg <= '0;
      acc_pwr_reg <= '0;
    end else if (i_clk_en) begin
      if (shunt_done) cur_hold_reg <= cur_s;
      if (bus_done) bus_hold_reg <= bus_s;
      if (acc_clear) begin
        sample_cnt_reg <= 11'h000;
        acc_cur_reg <= '0;
        acc_bus_reg <= '0;
        acc_pwr_reg <= '0;
      end else if (sample_end) begin
        sample_cnt_reg <= sample_cnt_reg + 11'h001; // RULE3
        acc_cur_reg <= acc_cur_next;
        acc_bus_reg <= acc_bus_next;
        acc_pwr_reg <= acc_pwr_next;
      end
    end
  end

  // a write that lands on the final sample still loads that set
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_reg <= '{cur: mcseq_pkg::RES_RESET, bus: mcseq_pkg::RES_RESET,
                   pwr: mcseq_pkg::RES_RESET};
    end else if (i_clk_en && set_done) begin
      res_reg <= res_new; // RULE4 RULE19
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_ready_on_done: assert property ( // RULE13
    i_clk_en && set_done |=> o_conversion_ready_flag)
    else $error("ready flag not set after result set");
  a_cfg_clears_ready: assert property ( // RULE14
    i_clk_en && cfg_wr && !new_pd && !set_done |=> !o_conversion_ready_flag)
    else $error("config write left ready flag set");
  a_mask_rd_clears: assert property ( // RULE15
    i_clk_en && mask_rd && !set_done |=> !o_conversion_ready_flag)
    else $error("mask read left ready flag set");
  a_results_hold: assert property ( // RULE4
    !(i_clk_en && set_done) |=> $stable(res_reg))
    else $error("results changed without completed set");
  a_pd_no_start: assert property ( // RULE9
    o_inputs_off |-> !o_conv_start)
    else $error("conversion started in power-down");
  a_wake_wait: assert property ( // RULE10
    i_clk_en && !cfg_wr && state_reg == mcseq_pkg::ST_WAKE &&
    wake_cnt_reg != 13'h0000 |=> state_reg == mcseq_pkg::ST_WAKE)
    else $error("left recovery early");
  a_single_shot_stop: assert property ( // RULE7
    i_clk_en && !cfg_wr && set_done && !mode_cont
    |=> state_reg == mcseq_pkg::ST_IDLE && !o_conv_start)
    else $error("triggered mode did not stop");
  a_cont_restart: assert property ( // RULE22
    i_clk_en && !cfg_wr && set_done && mode_cont
    |=> o_conv_start && sample_cnt_reg == 11'h000 && acc_bus_reg == '0)
    else $error("continuous mode did not restart cleared");
  a_read_no_disturb: assert property ( // RULE5
    i_clk_en && i_reg_rd && !i_reg_wr && !i_conv_valid &&
    state_reg == mcseq_pkg::ST_SWAIT |=> state_reg == mcseq_pkg::ST_SWAIT)
    else $error("read disturbed conversion");
  a_cfg_pd_halts: assert property ( // RULE9
    i_clk_en && cfg_wr && new_pd
    |=> state_reg == mcseq_pkg::ST_IDLE && o_inputs_off)
    else $error("power-down write did not halt");
  a_wake_rewrite: assert property ( // RULE10
    i_clk_en && cfg_wr && !new_pd && state_reg == mcseq_pkg::ST_WAKE
    |=> state_reg == mcseq_pkg::ST_WAKE)
    else $error("rewrite during recovery skipped the wait");
  a_shunt_mode: assert property ( // RULE6
    o_conv_start && !o_conv_sel |-> mode[mcseq_pkg::MODE_CUR_BIT])
    else $error("shunt start in a mode without current");
  a_bus_mode: assert property ( // RULE6
    o_conv_start && o_conv_sel |-> mode[mcseq_pkg::MODE_BUS_BIT])
    else $error("bus start in a mode without bus voltage");
  a_cfg_write_lands: assert property ( // RULE11
    i_clk_en && cfg_wr |=> cfg_reg == $past(i_reg_wdata))
    else $error("configuration write lost");

endmodule // mcseq_core

// File: mcseq_conv_model.sv
// converter stand-in: answers each start with one valid data pulse after i_delay cycles, none when i_delay is 0
// assumes start and channel select are registered by the sequencer
`timescale 1ns/1ps

module mcseq_conv_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_conv_start,
  input wire logic i_conv_sel,
  input wire logic [7:0] i_delay,
  input wire logic [15:0] i_cur_code,
  input wire logic [15:0] i_bus_code,
  output logic o_conv_valid,
  output logic [15:0] o_conv_data
);
  int wait_cnt;
  logic sel_reg;

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt <= 0;
      sel_reg <= 1'b0;
      o_conv_valid <= 1'b0;
      o_conv_data <= 16'h0000;
    end else begin
      // a new start aborts the old one, as a real converter restarts
      o_conv_valid <= 1'b0;
      o_conv_data <= ~o_conv_data;
      if (i_conv_start) begin
        wait_cnt <= int'(i_delay);
        sel_reg <= i_conv_sel;
      end else if (wait_cnt == 1) begin
        wait_cnt <= 0;
        o_conv_valid <= 1'b1;
        o_conv_data <= sel_reg ? i_bus_code : i_cur_code;
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule // mcseq_conv_model

// File: measurement_conversion_sequencer_tb.sv
// self-checking bench for the sequencer core over its register port
// assumes the converter model above and a clock enable held high except during the frozen-write check
`timescale 1ns/1ps

module measurement_conversion_sequencer_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [7:0] delay = 8'h02;
  logic [15:0] cur = 16'h2710;
  logic [15:0] bus = 16'h2570;
  logic conv_valid;
  logic [15:0] conv_data;
  logic [15:0] reg_rdata;
  logic conv_start;
  logic conv_sel;
  logic inputs_off;
  logic flag;
  mcseq_pkg::mcseq_result_t exp_r;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int n_shunt = 0;
  int n_bus = 0;
  int s0 = 0;
  int b0 = 0;
  int n;

  always #5 i_sys_clk = ~i_sys_clk;

  mcseq_core mcseq_core_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_clk_en(clk_en), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_conv_valid(conv_valid), .i_conv_data(conv_data),
    .o_reg_rdata(reg_rdata), .o_conv_start(conv_start),
    .o_conv_sel(conv_sel), .o_inputs_off(inputs_off),
    .o_conversion_ready_flag(flag));

  mcseq_conv_model mcseq_conv_model_i (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_conv_start(conv_start), .i_conv_sel(conv_sel),
    .i_delay(delay), .i_cur_code(cur), .i_bus_code(bus),
    .o_conv_valid(conv_valid), .o_conv_data(conv_data));

  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1 && conv_sel === 1'b0) n_shunt <= n_shunt + 1;
    if (conv_start === 1'b1 && conv_sel === 1'b1) n_bus <= n_bus + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    checked = checked + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge i_sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk16(nm, e, reg_rdata);
  endtask

  task automatic wait_flag(input int lim);
    int k = 0;
    while (flag !== 1'b1 && k < lim) begin
      @(posedge i_sys_clk);
      #1;
      k = k + 1;
    end
    chk16("ready_flag", 16'h0001, {15'h0000, flag});
  endtask

  task automatic mark();
    s0 = n_shunt;
    b0 = n_bus;
  endtask

  task automatic counts(input int es, input int eb);
    chk16("shunt_starts", 16'(es), 16'(n_shunt - s0));
    chk16("bus_starts", 16'(eb), 16'(n_bus - b0));
  endtask

  // expected results from the raw codes; power is |I|*V scaled
  task automatic chk_res();
    longint mag;
    longint p;
    mag = cur[15] ? 65536 - longint'(cur) : longint'(cur);
    exp_r.cur = cur;
    exp_r.bus = bus[15] ? mcseq_pkg::BUS_FULL_SCALE : bus;
    p = (mag * exp_r.bus * mcseq_pkg::PWR_RECIP) >> mcseq_pkg::PWR_SHIFT;
    exp_r.pwr = (p > 65535) ? mcseq_pkg::PWR_MAX : p[15:0];
    rd(mcseq_pkg::REG_CUR, exp_r.cur, "current");
    rd(mcseq_pkg::REG_BUS, exp_r.bus, "bus");
    rd(mcseq_pkg::REG_PWR, exp_r.pwr, "power");
  endtask

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(mcseq_pkg::REG_CFG, mcseq_pkg::CFG_RESET, "cfg_reset");
    rd(mcseq_pkg::REG_MASK, mcseq_pkg::MASK_RESET, "mask_reset");
    rd(8'h04, 16'h0000, "unmapped");
    wait_flag(5000);
    chk_res();
    wr(mcseq_pkg::REG_CFG, 16'h0003);
    mark();
    wait_flag(100);
    repeat (100) @(posedge i_sys_clk);
    counts(1, 1);
    chk_res();
    rd(mcseq_pkg::REG_MASK, 16'h0008, "mask_flag");
    rd(mcseq_pkg::REG_MASK, 16'h0000, "mask_clear");
    wr(mcseq_pkg::REG_CFG, 16'h0003);
    wait_flag(100);
    wr(mcseq_pkg::REG_CFG, 16'h0003);
    chk16("flag_cfg_wr", 16'h0000, {15'h0000, flag});
    wait_flag(100);
    // reverse current and saturated bus, one channel at a time, then both together
    cur = 16'hD8F0;
    bus = 16'h8000;
    wr(mcseq_pkg::REG_CFG, 16'h0001);
    mark();
    wait_flag(100);
    counts(1, 0);
    rd(mcseq_pkg::REG_CUR, cur, "cur_only");
    wr(mcseq_pkg::REG_CFG, 16'h0002);
    mark();
    wait_flag(100);
    counts(0, 1);
    rd(mcseq_pkg::REG_BUS, 16'h7FFF, "bus_only");
    wr(mcseq_pkg::REG_CFG, 16'h0003);
    wait_flag(100);
    chk_res();
    // four-sample average; old results must hold while reads go on
    cur = 16'h2710;
    bus = 16'h2570;
    wr(mcseq_pkg::REG_CFG, 16'h0203);
    mark();
    rd(mcseq_pkg::REG_CUR, 16'hD8F0, "cur_hold");
    rd(mcseq_pkg::REG_PWR, exp_r.pwr, "pwr_hold");
    wait_flag(200);
    counts(4, 4);
    chk_res();
    wr(mcseq_pkg::REG_CUR, 16'h1234);
    rd(mcseq_pkg::REG_CUR, 16'h2710, "cur_read_only");
    // power-down keeps flag and registers live
    wr(mcseq_pkg::REG_CFG, 16'h0000);
    mark();
    chk16("inputs_off", 16'h0001, {15'h0000, inputs_off});
    wr(mcseq_pkg::REG_MASK, 16'h0400);
    rd(mcseq_pkg::REG_MASK, 16'h0408, "mask_pd");
    rd(mcseq_pkg::REG_CFG, 16'h0000, "cfg_pd");
    // a write while the clock enable is low must be lost
    clk_en <= 1'b0;
    wr(mcseq_pkg::REG_CFG, 16'h0003);
    clk_en <= 1'b1;
    rd(mcseq_pkg::REG_CFG, 16'h0000, "cfg_frozen");
    repeat (50) @(posedge i_sys_clk);
    counts(0, 0);
    wr(mcseq_pkg::REG_CFG, 16'h0003);
    n = 0;
    while (conv_start !== 1'b1 && n < 5000) begin
      @(posedge i_sys_clk);
      #1;
      n = n + 1;
    end
    chk16("wake_gap", 16'h0001, {15'h0000, n >= 4000 && n <= 4004});
    chk16("inputs_on", 16'h0000, {15'h0000, inputs_off});
    wait_flag(100);
    // slow converter, config rewritten while a bus conversion runs
    delay = 8'd20;
    wr(mcseq_pkg::REG_CFG, 16'h0007);
    n = 0;
    while (!(conv_start === 1'b1 && conv_sel === 1'b1) && n < 200) begin
      @(posedge i_sys_clk);
      #1;
      n = n + 1;
    end
    wr(mcseq_pkg::REG_CFG, 16'h0003);
    mark();
    wait_flag(200);
    counts(1, 1);
    chk_res();
    stop_test();
  end
endmodule // measurement_conversion_sequencer_tb
